// [rtl/etvh_pkg.sv]
// etvh package: register map, descriptor layout, dma states and tag hash
// Behaviour
// - flag target on first increment reaching it
// - enabled target flag raises the interrupt
// - chained mode follows the descriptor link word
// - chain flag selects chained or unchained
// - unchained stride is size plus skip words
// - unchained link word is second buffer
// - host-owned descriptor suspends until poll demand
// - poll re-reads descriptor, resumes if owned
// - flush discards words held in fifo
// - words already at mac still go out
// - current buffer address is readable
// - current descriptor address is readable
// - list base reads back, dma starts there
// - tag hashes to one of sixteen bits
// - any tag on a set bit passes
// - hash select picks hash over perfect match
package etvh_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_BASE = 8'h08;
  localparam logic [7:0] REG_CDSC = 8'h0C;
  localparam logic [7:0] REG_CBUF = 8'h10;
  localparam logic [7:0] REG_POLL = 8'h14;
  localparam logic [7:0] REG_SKIP = 8'h18;
  localparam logic [7:0] REG_TSEC = 8'h1C;
  localparam logic [7:0] REG_TSUB = 8'h20;
  localparam logic [7:0] REG_HASH = 8'h24;
  localparam logic [7:0] REG_VTAG = 8'h28;
  // control and status bit positions
  localparam int CTRL_TXEN = 0;
  localparam int CTRL_FLUSH = 1;
  localparam int CTRL_TGTIE = 2;
  localparam int CTRL_HSEL = 3;
  localparam int CTRL_TAG12 = 4;
  localparam int STAT_TGT = 0;
  // descriptor fields
  localparam int D0_OWN = 31;
  localparam int D0_LAST = 29;
  localparam int D0_CHAIN = 20;
  localparam int D1_SZ2 = 16;
  localparam int SZ_W = 13;
  localparam logic [31:0] DESC_BYTES = 32'h00000010;
  localparam logic [31:0] WORD_BYTES = 32'h00000004;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  // dma states
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_D0 = 9'h002,
    S_D1 = 9'h004,
    S_D2 = 9'h008,
    S_D3 = 9'h010,
    S_BUF1 = 9'h020,
    S_BUF2 = 9'h040,
    S_WB = 9'h080,
    S_SUSP = 9'h100
  } etvh_state_t;
  // fold a tag into a filter bit number
  function automatic logic [3:0] etvhHash(input logic [15:0] tag, input logic tag12);
    etvhHash = tag[3:0] ^ tag[7:4] ^ tag[11:8] ^ (tag12 ? 4'h0 : tag[15:12]);
  endfunction
  // merge written byte lanes into a word
  function automatic logic [31:0] etvhMerge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      etvhMerge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction
  // byte count rounded up to words
  function automatic logic [11:0] etvhWords(input logic [SZ_W-1:0] sz);
    logic [13:0] t;
    t = {1'b0, sz} + 14'h0003;
    etvhWords = t[13:2];
  endfunction
endpackage

// [rtl/etvh_vlan_filter.sv]
// etvh vlan filter: registered pass verdict for each received tag
`timescale 1ns/1ps
module etvh_vlan_filter import etvh_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // received tag
  input wire logic tagValid,
  input wire logic [15:0] tag,
  // configuration
  input wire logic hashSel,
  input wire logic tag12,
  input wire logic [15:0] hash,
  input wire logic [15:0] perfTag,
  // verdict
  output logic passValid,
  output logic pass
);
  typedef struct packed {
    logic v;
    logic p;
  } etvh_filt_t;
  etvh_filt_t f_q;
  etvh_filt_t f_d;
  logic [3:0] idx;
  logic [15:0] mask;
  logic perfHit;

  // hash index and perfect compare
  assign idx = etvhHash(tag, tag12);
  assign mask = tag12 ? 16'h0FFF : 16'hFFFF;
  assign perfHit = ((tag & mask) == (perfTag & mask)) | (tag12 & (perfTag[11:0] == 12'h000));

  // verdict select
  always_comb begin
    f_d.v = tagValid;
    f_d.p = f_q.p;
    if (tagValid) begin
      f_d.p = hashSel ? hash[idx] : perfHit;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  assign passValid = f_q.v;
  assign pass = f_q.p;

  property p_hash;
    @(posedge mclk) disable iff (!resetn)
    tagValid && hashSel |=> passValid && (pass == $past(hash[idx]));
  endproperty
  a_hash: assert property (p_hash) else $error("hash verdict wrong");
  property p_perf;
    @(posedge mclk) disable iff (!resetn)
    tagValid && !hashSel && (tag == perfTag) |=> pass;
  endproperty
  a_perf: assert property (p_perf) else $error("perfect match dropped");
endmodule

// [rtl/etvh_top.sv]
// etvh top: tx descriptor dma, flush, target time event and vlan filter regs
`timescale 1ns/1ps
module etvh_top import etvh_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // dma memory master
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [31:0] memWData,
  input wire logic memAck,
  input wire logic [31:0] memRData,
  // transmit words to mac
  output logic txValid,
  output logic [31:0] txData,
  output logic txLast,
  input wire logic txReady,
  // system time
  input wire logic sysTimeInc,
  input wire logic [31:0] sysTimeSec,
  input wire logic [31:0] sysTimeSub,
  // received vlan tag
  input wire logic rxTagValid,
  input wire logic [15:0] rxTag,
  output logic rxTagPassValid,
  output logic rxTagPass,
  // interrupt
  output logic irq
);
  typedef struct packed {
    etvh_state_t st;
    logic waitReq;
    logic [31:0] rdData;
    logic txEn;
    logic tgtIe;
    logic hashSel;
    logic tag12;
    logic tgtStat;
    logic tgtArmed;
    logic irq;
    logic [31:0] base;
    logic [31:0] curDesc;
    logic [31:0] curBuf;
    logic [31:0] tgtSec;
    logic [31:0] tgtSub;
    logic [31:0] d0;
    logic [31:0] link;
    logic [15:0] hash;
    logic [15:0] vtag;
    logic [7:0] skip;
    logic [SZ_W-1:0] sz1;
    logic [SZ_W-1:0] sz2;
    logic [11:0] remW;
    logic memReq;
    logic memWe;
    logic [31:0] memAddr;
    logic [31:0] memWData;
    logic fifoV;
    logic fifoL;
    logic [31:0] fifoD;
    logic txV;
    logic txL;
    logic [31:0] txD;
    logic flushPend;
  } etvh_regs_t;

  etvh_regs_t s_q;
  etvh_regs_t s_d;
  logic [7:0] regAddr;
  logic [31:0] ctrlWord;
  logic [31:0] seqNext;
  logic busWr;
  logic poll;
  logic flush;
  logic tgtHit;

  // start a memory access and move to a state
  function automatic etvh_regs_t issue(input etvh_regs_t s, input logic we,
      input logic [31:0] a, input etvh_state_t st);
    issue = s;
    issue.memReq = 1'b1;
    issue.memWe = we;
    issue.memAddr = a;
    issue.st = st;
  endfunction

  // decode helpers
  assign regAddr = {avsAddress[7:2], 2'b00};
  assign ctrlWord = {27'h0000000, s_q.tag12, s_q.hashSel, s_q.tgtIe, 1'b0, s_q.txEn};
  assign seqNext = s_q.curDesc + DESC_BYTES + {22'h000000, s_q.skip, 2'b00};
  assign tgtHit = sysTimeInc & s_q.tgtArmed &
                  ({sysTimeSec, sysTimeSub} >= {s_q.tgtSec, s_q.tgtSub});

  // next state of bus, registers, dma and output stage
  always_comb begin
    logic [31:0] wd;
    logic [31:0] rv;
    logic [SZ_W-1:0] sz2e;
    wd = RST_WORD;
    rv = RST_WORD;
    sz2e = s_q.d0[D0_CHAIN] ? '0 : s_q.sz2;
    s_d = s_q;
    busWr = avsWrite & ~s_q.waitReq;
    poll = 1'b0;
    flush = 1'b0;
    // read mux, unmapped reads return zero
    case (regAddr)
      REG_CTRL: rv = ctrlWord;
      REG_STAT: rv = {29'h0000000, s_q.st != S_IDLE && s_q.st != S_SUSP,
                      s_q.st == S_SUSP, s_q.tgtStat};
      REG_BASE: rv = s_q.base;
      REG_CDSC: rv = s_q.curDesc;
      REG_CBUF: rv = s_q.curBuf;
      REG_SKIP: rv = {24'h000000, s_q.skip};
      REG_TSEC: rv = s_q.tgtSec;
      REG_TSUB: rv = s_q.tgtSub;
      REG_HASH: rv = {16'h0000, s_q.hash};
      REG_VTAG: rv = {16'h0000, s_q.vtag};
      default: rv = RST_WORD;
    endcase
    // one wait cycle per access
    s_d.waitReq = 1'b1;
    if ((avsRead | avsWrite) & s_q.waitReq) begin
      s_d.waitReq = 1'b0;
      s_d.rdData = rv;
    end
    // register writes on the accepting edge
    if (busWr) begin
      case (regAddr)
        REG_CTRL: begin
          wd = etvhMerge(ctrlWord, avsWriteData, avsByteEnable);
          s_d.txEn = wd[CTRL_TXEN];
          s_d.tgtIe = wd[CTRL_TGTIE];
          s_d.hashSel = wd[CTRL_HSEL];
          s_d.tag12 = wd[CTRL_TAG12];
          flush = wd[CTRL_FLUSH];
        end
        REG_STAT: begin
          wd = etvhMerge(RST_WORD, avsWriteData, avsByteEnable);
          if (wd[STAT_TGT]) begin
            s_d.tgtStat = 1'b0;
          end
        end
        REG_BASE: s_d.base = etvhMerge(s_q.base, avsWriteData, avsByteEnable);
        REG_POLL: poll = 1'b1;
        REG_SKIP: begin
          wd = etvhMerge({24'h000000, s_q.skip}, avsWriteData, avsByteEnable);
          s_d.skip = wd[7:0];
        end
        REG_TSEC: begin
          s_d.tgtSec = etvhMerge(s_q.tgtSec, avsWriteData, avsByteEnable);
          s_d.tgtArmed = 1'b1;
        end
        REG_TSUB: begin
          s_d.tgtSub = etvhMerge(s_q.tgtSub, avsWriteData, avsByteEnable);
          s_d.tgtArmed = 1'b1;
        end
        REG_HASH: begin
          wd = etvhMerge({16'h0000, s_q.hash}, avsWriteData, avsByteEnable);
          s_d.hash = wd[15:0];
        end
        REG_VTAG: begin
          wd = etvhMerge({16'h0000, s_q.vtag}, avsWriteData, avsByteEnable);
          s_d.vtag = wd[15:0];
        end
        default: ;
      endcase
    end
    // target event fires once per arming, set beats clear
    if (tgtHit) begin
      s_d.tgtStat = 1'b1;
      s_d.tgtArmed = 1'b0;
    end
    s_d.irq = s_d.tgtStat & s_d.tgtIe;
    // fifo word to mac stage; a flushed word never moves
    if (s_q.txV & txReady) begin
      s_d.txV = 1'b0;
    end
    if (s_q.fifoV & ~flush & ~s_d.txV) begin
      s_d.txV = 1'b1;
      s_d.txD = s_q.fifoD;
      s_d.txL = s_q.fifoL;
      s_d.fifoV = 1'b0;
    end
    // descriptor engine
    case (s_q.st)
      S_IDLE: begin
        if (s_q.txEn) begin
          s_d = issue(s_d, 1'b0, s_q.base, S_D0);
          s_d.curDesc = s_q.base;
        end
      end
      S_D0: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.d0 = memRData;
          if (!memRData[D0_OWN]) begin
            s_d.st = S_SUSP;
          end else begin
            s_d = issue(s_d, 1'b0, s_q.curDesc + WORD_BYTES, S_D1);
          end
        end
      end
      S_D1: begin
        if (memAck) begin
          s_d.sz1 = memRData[SZ_W-1:0];
          s_d.sz2 = memRData[D1_SZ2 +: SZ_W];
          s_d = issue(s_d, 1'b0, s_q.curDesc + 2 * WORD_BYTES, S_D2);
        end
      end
      S_D2: begin
        if (memAck) begin
          s_d.curBuf = memRData;
          s_d = issue(s_d, 1'b0, s_q.curDesc + 3 * WORD_BYTES, S_D3);
        end
      end
      S_D3: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.link = memRData;
          s_d.remW = etvhWords(s_q.sz1);
          s_d.st = S_BUF1;
        end
      end
      S_BUF1, S_BUF2: begin
        if (s_q.memReq) begin
          if (memAck) begin
            s_d.memReq = 1'b0;
            s_d.curBuf = s_q.curBuf + WORD_BYTES;
            s_d.remW = s_q.remW - 12'h001;
            if (!s_q.flushPend) begin
              s_d.fifoV = 1'b1;
              s_d.fifoD = memRData;
              s_d.fifoL = s_q.d0[D0_LAST] & (s_q.remW == 12'h001) &
                          ((s_q.st == S_BUF2) | (sz2e == '0));
            end
          end
        end else if (s_q.flushPend | (s_q.remW == 12'h000)) begin
          if ((s_q.st == S_BUF1) & ~s_q.flushPend & (sz2e != '0)) begin
            s_d.st = S_BUF2;
            s_d.curBuf = s_q.link;
            s_d.remW = etvhWords(sz2e);
          end else begin
            s_d.flushPend = 1'b0;
            s_d.memWData = s_q.d0 & ~(32'h00000001 << D0_OWN);
            s_d = issue(s_d, 1'b1, s_q.curDesc, S_WB);
          end
        end else if (!s_q.fifoV) begin
          s_d = issue(s_d, 1'b0, s_q.curBuf, s_q.st);
        end
      end
      S_WB: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.memWe = 1'b0;
          s_d.curDesc = s_q.d0[D0_CHAIN] ? s_q.link : seqNext;
          s_d.st = S_IDLE;
          if (s_q.txEn) begin
            s_d = issue(s_d, 1'b0, s_d.curDesc, S_D0);
          end
        end
      end
      S_SUSP: begin
        if (poll) begin
          s_d = issue(s_d, 1'b0, s_q.curDesc, S_D0);
        end
      end
      default: s_d.st = S_IDLE;
    endcase
    // flush empties the fifo and drops words still in flight
    if (flush) begin
      s_d.fifoV = 1'b0;
      if ((s_q.st == S_BUF1) | (s_q.st == S_BUF2)) begin
        s_d.flushPend = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.waitReq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // vlan tag filter
  etvh_vlan_filter etvh_vlan_filter_inst (
    .mclk(mclk),
    .resetn(resetn),
    .tagValid(rxTagValid),
    .tag(rxTag),
    .hashSel(s_q.hashSel),
    .tag12(s_q.tag12),
    .hash(s_q.hash),
    .perfTag(s_q.vtag),
    .passValid(rxTagPassValid),
    .pass(rxTagPass)
  );

  // outputs straight from the state register
  assign avsReadData = s_q.rdData;
  assign avsWaitRequest = s_q.waitReq;
  assign memReq = s_q.memReq;
  assign memWe = s_q.memWe;
  assign memAddr = s_q.memAddr;
  assign memWData = s_q.memWData;
  assign txValid = s_q.txV;
  assign txData = s_q.txD;
  assign txLast = s_q.txL;
  assign irq = s_q.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_tgt_hit;
    tgtHit |=> s_q.tgtStat && !s_q.tgtArmed;
  endproperty
  a_tgt_hit: assert property (p_tgt_hit) else $error("target not flagged");
  property p_tgt_cause;
    $rose(s_q.tgtStat) |-> $past(sysTimeInc) && $past(s_q.tgtArmed);
  endproperty
  a_tgt_cause: assert property (p_tgt_cause) else $error("target flag w/o hit");
  property p_irq;
    ($rose(s_q.tgtStat) && s_q.tgtIe |-> irq) and (irq |-> s_q.tgtStat);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_chain;
    s_q.st == S_WB && memAck && s_q.txEn && s_q.d0[D0_CHAIN]
      |=> s_q.st == S_D0 && memAddr == $past(s_q.link);
  endproperty
  a_chain: assert property (p_chain) else $error("chain link not used");
  property p_stride;
    s_q.st == S_WB && memAck && s_q.txEn && !s_q.d0[D0_CHAIN]
      |=> s_q.st == S_D0 && memAddr == $past(seqNext);
  endproperty
  a_stride: assert property (p_stride) else $error("bad stride");
  property p_buf2;
    $rose(s_q.st == S_BUF2) |-> !s_q.d0[D0_CHAIN] && s_q.curBuf == s_q.link;
  endproperty
  a_buf2: assert property (p_buf2) else $error("second buffer wrong");
  property p_susp;
    s_q.st == S_D0 && memAck && !memRData[D0_OWN] |=> s_q.st == S_SUSP && !memReq;
  endproperty
  a_susp: assert property (p_susp) else $error("no suspend");
  property p_poll;
    s_q.st == S_SUSP |=> (s_q.st == S_SUSP) == !$past(poll);
  endproperty
  a_poll: assert property (p_poll) else $error("poll resume wrong");
  property p_reread;
    s_q.st == S_SUSP && poll |=> memReq && !memWe && memAddr == $past(s_q.curDesc);
  endproperty
  a_reread: assert property (p_reread) else $error("no re-read");
  property p_flush;
    flush |=> !s_q.fifoV ##1 !s_q.fifoV;
  endproperty
  a_flush: assert property (p_flush) else $error("fifo not flushed");
  property p_hold;
    flush && s_q.txV && !txReady |=> s_q.txV && s_q.txD == $past(s_q.txD);
  endproperty
  a_hold: assert property (p_hold) else $error("mac word lost");
  property p_start;
    s_q.st == S_IDLE && s_q.txEn |=> memReq && memAddr == $past(s_q.base);
  endproperty
  a_start: assert property (p_start) else $error("not started at base");

  c_susp: cover property (s_q.st == S_SUSP ##[1:50] poll);
  c_buf2: cover property (s_q.st == S_BUF2 && txValid);
  c_tgt: cover property (tgtHit && s_q.tgtIe);
  c_flush: cover property (flush && s_q.st == S_BUF1);
endmodule

// [dv/etvh_mem_model.sv]
// etvh partner: system memory answering the dma and a mac sink
`timescale 1ns/1ps
module etvh_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // answer pacing
  input wire logic slowMode,
  input wire logic txHold,
  // dma memory slave
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWData,
  output logic memAck,
  output logic [31:0] memRData,
  // mac sink
  input wire logic txValid,
  input wire logic [31:0] txData,
  input wire logic txLast,
  output logic txReady
);
  logic [31:0] mem [0:1023];
  logic [31:0] txWords [$];
  logic txLasts [$];
  int waitCnt;
  logic tog;
  // mac stalls on hold, and every other cycle when slow
  assign txReady = !txHold && !(slowMode && tog);
  // acks after a delay; read data is junk outside the ack cycle
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      memAck <= 1'b0;
      memRData <= 32'h5A5A5A5A;
      waitCnt <= 0;
      tog <= 1'b0;
    end else begin
      tog <= !tog;
      memAck <= 1'b0;
      memRData <= ~memRData;
      if (memAck && memWe) begin
        mem[memAddr[11:2]] <= memWData;
      end
      if (memReq && !memAck) begin
        if (waitCnt >= (slowMode ? 3 : 0)) begin
          memAck <= 1'b1;
          waitCnt <= 0;
          if (!memWe) begin
            memRData <= mem[memAddr[11:2]];
          end
        end else begin
          waitCnt <= waitCnt + 1;
        end
      end
      if (txValid && txReady) begin
        txWords.push_back(txData);
        txLasts.push_back(txLast);
      end
    end
  end
endmodule

// [dv/etvh_top_tb.sv]
// etvh bench: register bus, tx dma, flush, target time and vlan filter
`timescale 1ns/1ps
module etvh_top_tb import etvh_pkg::*;;
  int err_total = 0;
  int n_compared = 0;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avsAddress = 8'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h00000000;
  logic [3:0] avsByteEnable = 4'hF;
  logic sysTimeInc = 1'b0;
  logic [31:0] sysTimeSec = 32'h00000000;
  logic [31:0] sysTimeSub = 32'h00000000;
  logic rxTagValid = 1'b0;
  logic [15:0] rxTag = 16'h0000;
  logic slowMode = 1'b0;
  logic txHold = 1'b0;
  logic [31:0] avsReadData, memAddr, memWData, memRData, txData;
  logic avsWaitRequest, memReq, memWe, memAck, txValid, txLast, txReady;
  logic rxTagPassValid, rxTagPass, irq;
  // clock
  always #20 mclk = ~mclk;
  // device and its partner
  etvh_top etvh_top_inst (.mclk(mclk), .resetn(resetn), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWData(memWData), .memAck(memAck), .memRData(memRData), .txValid(txValid),
    .txData(txData), .txLast(txLast), .txReady(txReady), .sysTimeInc(sysTimeInc),
    .sysTimeSec(sysTimeSec), .sysTimeSub(sysTimeSub), .rxTagValid(rxTagValid),
    .rxTag(rxTag), .rxTagPassValid(rxTagPassValid), .rxTagPass(rxTagPass), .irq(irq));
  etvh_mem_model etvh_mem_model_inst (.mclk(mclk), .resetn(resetn), .slowMode(slowMode),
    .txHold(txHold), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWData(memWData), .memAck(memAck), .memRData(memRData), .txValid(txValid),
    .txData(txData), .txLast(txLast), .txReady(txReady));
  // comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string s);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, s, seen, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic busAcc(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    @(posedge mclk);
    avsAddress <= a;
    avsWriteData <= d;
    avsByteEnable <= be;
    avsWrite <= wr;
    avsRead <= !wr;
    // only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge mclk);
    end while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busAcc(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] q;
    busAcc(1'b0, a, 32'h0, 4'hF, q);
    check(q, e, s);
  endtask
  // memory helpers
  task automatic setW(input logic [31:0] a, input logic [31:0] d);
    etvh_mem_model_inst.mem[a[11:2]] = d;
  endtask
  function automatic logic [31:0] memW(input logic [31:0] a);
    return etvh_mem_model_inst.mem[a[11:2]];
  endfunction
  task automatic setD(input logic [31:0] a, input logic [31:0] w0, w1, w2, w3);
    setW(a, w1);
    setW(a + 4, w1);
    setW(a + 8, w2);
    setW(a + 12, w3);
    setW(a, w0);
  endtask
  task automatic cntChk(input int n);
    check(32'(etvh_mem_model_inst.txWords.size()), 32'(n), "tx count");
  endtask
  task automatic txChk(input int i, input logic [31:0] w, input logic l);
    check(etvh_mem_model_inst.txWords[i], w, "tx word");
    check({31'h0, etvh_mem_model_inst.txLasts[i]}, {31'h0, l}, "tx last");
  endtask
  // polls status until the dma reports suspended
  task automatic waitSusp();
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h0;
    while (q[1] !== 1'b1 && n < 200) begin
      busAcc(1'b0, REG_STAT, 32'h0, 4'hF, q);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      results();
    end
  endtask
  task automatic sysInc(input logic [31:0] s, input logic [31:0] u);
    @(posedge mclk);
    sysTimeInc <= 1'b1;
    sysTimeSec <= s;
    sysTimeSub <= u;
    @(posedge mclk);
    sysTimeInc <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic tagChk(input logic [15:0] t, input logic e);
    @(posedge mclk);
    rxTagValid <= 1'b1;
    rxTag <= t;
    @(posedge mclk);
    rxTagValid <= 1'b0;
    @(posedge mclk);
    check({31'h0, rxTagPassValid}, 32'h1, "strobe");
    check({31'h0, rxTagPass}, {31'h0, e}, "verdict");
  endtask
  // reset values, unmapped place, chained descriptor with a slow partner
  task automatic tChain();
    rdChk(REG_CTRL, 32'h0, "ctrl");
    rdChk(REG_BASE, 32'h0, "base");
    wr(8'h3C, 32'hFFFFFFFF);
    rdChk(8'h3C, 32'h0, "unmapped");
    slowMode <= 1'b1;
    setD(32'h100, 32'h80100000, 32'h8, 32'h400, 32'h200);
    setD(32'h200, 32'h0, 32'h00040004, 32'h500, 32'h600);
    setD(32'h218, 32'h0, 32'h10, 32'h700, 32'h0);
    setD(32'h230, 32'h0, 32'h0, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++) setW(32'h700 + 4 * i, 32'h44440000 + i);
    setW(32'h400, 32'h11110001);
    setW(32'h404, 32'h11110002);
    setW(32'h500, 32'h22220003);
    setW(32'h600, 32'h33330004);
    wr(REG_SKIP, 32'h2);
    wr(REG_BASE, 32'h100);
    rdChk(REG_BASE, 32'h100, "base");
    wr(REG_CTRL, 32'h1);
    waitSusp();
    cntChk(2);
    txChk(0, 32'h11110001, 1'b0);
    txChk(1, 32'h11110002, 1'b0);
    rdChk(REG_CDSC, 32'h200, "cur desc");
    check(memW(32'h100), 32'h00100000, "writeback");
  endtask
  // host-owned descriptor waits for a poll; unchained second buffer and stride
  task automatic tPoll();
    slowMode <= 1'b0;
    setW(32'h200, 32'hA0000000);
    repeat (10) @(posedge mclk);
    cntChk(2);
    wr(REG_POLL, 32'h0);
    waitSusp();
    cntChk(4);
    txChk(2, 32'h22220003, 1'b0);
    txChk(3, 32'h33330004, 1'b1);
    rdChk(REG_CDSC, 32'h218, "cur desc");
  endtask
  // flush while the mac stalls: only the staged word leaves
  task automatic tFlush();
    logic [31:0] q;
    txHold <= 1'b1;
    setW(32'h218, 32'h80000000);
    wr(REG_POLL, 32'h0);
    while (txValid !== 1'b1) begin
      @(posedge mclk);
    end
    repeat (20) @(posedge mclk);
    busAcc(1'b0, REG_CBUF, 32'h0, 4'hF, q);
    check({31'h0, q >= 32'h700 && q < 32'h710}, 32'h1, "cur buf");
    wr(REG_CTRL, 32'h3);
    txHold <= 1'b0;
    waitSusp();
    cntChk(5);
    txChk(4, 32'h44440000, 1'b0);
    check(memW(32'h218), 32'h0, "writeback");
    rdChk(REG_CDSC, 32'h230, "cur desc");
  endtask
  // target time compare and its interrupt
  task automatic tTarget();
    wr(REG_CTRL, 32'h5);
    wr(REG_TSEC, 32'h5);
    wr(REG_TSUB, 32'h64);
    sysInc(32'h5, 32'h63);
    rdChk(REG_STAT, 32'h2, "below");
    sysInc(32'h4, 32'hC8);
    rdChk(REG_STAT, 32'h2, "earlier second");
    sysInc(32'h5, 32'h64);
    check({31'h0, irq}, 32'h1, "irq");
    rdChk(REG_STAT, 32'h3, "equal");
    wr(REG_STAT, 32'h1);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0, "irq clear");
    sysInc(32'h6, 32'h0);
    rdChk(REG_STAT, 32'h2, "disarmed");
  endtask
  // hash and perfect tag filtering
  task automatic tVlan();
    logic [31:0] q;
    wr(REG_HASH, 32'hFFFF);
    busAcc(1'b1, REG_HASH, 32'hAAAA0004, 4'h3, q);
    rdChk(REG_HASH, 32'h4, "hash");
    wr(REG_CTRL, 32'h9);
    tagChk(16'h0002, 1'b1);
    tagChk(16'h0020, 1'b1);
    tagChk(16'h1111, 1'b0);
    tagChk(16'h2000, 1'b1);
    wr(REG_CTRL, 32'h19);
    tagChk(16'h2000, 1'b0);
    wr(REG_VTAG, 32'h0123);
    wr(REG_CTRL, 32'h1);
    tagChk(16'h0123, 1'b1);
    tagChk(16'h0002, 1'b0);
    wr(REG_CTRL, 32'h11);
    tagChk(16'hF123, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    tChain();
    tPoll();
    tFlush();
    tTarget();
    tVlan();
    results();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    results();
  end
endmodule
